// ===== hw/dafs_seq.sv
// Operation
// - Select fall starts a frame, select rise ends it.
// - Result pin floats while select is high, driven while low.
// - Falling edges one to three are acquisition on both channels.
// - Next twelve clock cycles convert both channels, one bit per cycle.
// - Edges 1-4 send zeros, edges 5-16 send channel A MSB first.
// - Edges 17-20 send zeros, edges 21-32 send channel B MSB first.
// - After edge 32 acquisition restarts; conversion resumes at N*32+4.
// - Select falling with clock high: acquire at next clock fall.
// - Select falling with clock low counts as first falling edge.
// - Select and clock falling together: acquire immediately.
// - Both channels sampled together on the fourth falling edge.
// - Results are 12-bit two's complement, 7FF to 800.
// - Each channel result spans 4096 distinct codes.
// - Select rising before edge 16 aborts and floats the output.
// - Select held low keeps converting frame after frame.
// - Power-down while select high and after conversion completes.
`timescale 1ns/1ps
`include "dafs_map.svh"

module dafs_seq
  import dafs_pkg::*;
(
  input wire logic clk_i,                // 25 MHz system clock
  input wire logic rst_n_i,              // Sync reset, active low
  input wire logic cs_n_i,               // Chip select pin, active low
  input wire logic sclk_i,               // Serial clock pin
  input wire logic sample_valid_i,       // Result pair offered
  output logic sample_ready_o,           // Result pair taken
  input wire logic [`DAFS_RES_W-1:0] channel_a_difference_input_i, // A code
  input wire logic [`DAFS_RES_W-1:0] channel_b_difference_input_i, // B code
  output logic sdata_o,                  // Serial result bit
  output logic sdata_oe_n_o,             // Result pin enable, active low
  output logic acquiring_o,              // Acquisition phase
  output logic converting_o,             // Conversion phase
  output logic power_down_o,             // Power-down phase
  output logic conv_abort_o              // Frame aborted, one cycle
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic in_span(input dafs_cnt_t k, input dafs_cnt_t lo,
                                   input dafs_cnt_t hi);
    in_span = (k >= lo) && (k <= hi);
  endfunction

  function automatic logic frame_bit(input dafs_cnt_t k,
                                     input dafs_word_t w);
    dafs_cnt_t off;
    off = `DAFS_EDGE_NONE;
    frame_bit = 1'b0;
    if (in_span(k, `DAFS_EDGE_A_LO, `DAFS_EDGE_A_HI)) begin
      off = `DAFS_EDGE_A_HI - k;
      frame_bit = w.a[off[3:0]];
    end else if (in_span(k, `DAFS_EDGE_B_LO, `DAFS_EDGE_B_HI)) begin
      off = `DAFS_EDGE_B_HI - k;
      frame_bit = w.b[off[3:0]];
    end
  endfunction

  function automatic dafs_state_t phase_of(input dafs_cnt_t k);
    if (k == `DAFS_EDGE_NONE) begin
      phase_of = DAFS_ARMED;
    end else if (in_span(k, `DAFS_EDGE_FIRST, `DAFS_EDGE_ACQ_HI)) begin
      phase_of = DAFS_ACQ;
    end else if (in_span(k, `DAFS_EDGE_CONV, `DAFS_EDGE_CONV_HI)) begin
      phase_of = DAFS_CONV;
    end else begin
      phase_of = DAFS_IDLE;
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic cs_m_q;
  logic cs_s_q;
  logic cs_p_q;
  logic clk_m_q;
  logic clk_s_q;
  logic clk_p_q;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      cs_p_q <= 1'b1;
    end else begin
      cs_m_q <= cs_n_i;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_m_q <= 1'b0;
      clk_s_q <= 1'b0;
      clk_p_q <= 1'b0;
    end else begin
      clk_m_q <= sclk_i;
      clk_s_q <= clk_m_q;
      clk_p_q <= clk_s_q;
    end
  end

  assign cs_fall = cs_p_q & ~cs_s_q;
  assign cs_rise = ~cs_p_q & cs_s_q;
  assign sclk_fall = clk_p_q & ~clk_s_q;

  // ---------------------------------------------------------------
  // Frame window
  // ---------------------------------------------------------------
  logic in_frame_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      in_frame_q <= 1'b0;
    end else if (cs_fall) begin
      in_frame_q <= 1'b1;
    end else if (cs_rise) begin
      in_frame_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Falling edge counter
  // ---------------------------------------------------------------
  dafs_cnt_t cnt_q;
  dafs_cnt_t cnt_d;
  logic tick;

  always_comb begin
    cnt_d = cnt_q;
    tick = 1'b0;
    if (cs_rise) begin
      cnt_d = `DAFS_EDGE_NONE;
    end else if (cs_fall) begin
      // low clock counts as edge one
      if (!clk_s_q) begin
        cnt_d = `DAFS_EDGE_FIRST;
        tick = 1'b1;
      end else begin
        cnt_d = `DAFS_EDGE_NONE;
      end
    end else if (in_frame_q && sclk_fall) begin
      tick = 1'b1;
      if (cnt_q == `DAFS_EDGE_LAST) begin
        cnt_d = `DAFS_EDGE_FIRST;
      end else begin
        cnt_d = cnt_q + `DAFS_EDGE_FIRST;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= `DAFS_EDGE_NONE;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Result buffer and sampling
  // ---------------------------------------------------------------
  dafs_stream_if #(.W(`DAFS_WORD_W)) push_if ();
  dafs_stream_if #(.W(`DAFS_WORD_W)) pop_if ();
  dafs_word_t word_q;
  logic conv_go;

  // two 12-bit two's complement codes per pair
  assign push_if.valid = sample_valid_i;
  assign push_if.data = {channel_a_difference_input_i,
                         channel_b_difference_input_i};
  assign sample_ready_o = push_if.ready;

  // both channels taken at edge N*32+4
  assign conv_go = tick && (cnt_d == `DAFS_EDGE_CONV);
  assign pop_if.ready = conv_go;

  dafs_fifo #(
    .WIDTH(`DAFS_WORD_W),
    .DEPTH(`DAFS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .push_s(push_if),
    .pop_s(pop_if)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      word_q <= '0;
    end else if (conv_go && pop_if.valid) begin
      word_q <= pop_if.data;
    end
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  logic sdata_q;
  logic oe_n_q;

  // zeros, then A, zeros, then B
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sdata_q <= 1'b0;
    end else if (cs_s_q) begin
      sdata_q <= 1'b0;
    end else if (tick) begin
      sdata_q <= frame_bit(cnt_d, conv_go ? pop_if.data : word_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= cs_s_q;
    end
  end

  assign sdata_o = sdata_q;
  assign sdata_oe_n_o = oe_n_q;

  // ---------------------------------------------------------------
  // Phase tracking
  // ---------------------------------------------------------------
  dafs_state_t state_q;
  logic abort_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= DAFS_DOWN;
    end else begin
      case (state_q)
        DAFS_DOWN: begin
          if (cs_fall) begin
            state_q <= phase_of(cnt_d);
          end
        end
        DAFS_ARMED, DAFS_ACQ, DAFS_CONV, DAFS_IDLE: begin
          if (cs_rise) begin
            state_q <= DAFS_DOWN;
          end else if (tick) begin
            state_q <= phase_of(cnt_d);
          end
        end
        default: begin
          state_q <= DAFS_DOWN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= cs_rise && in_frame_q && (cnt_q < `DAFS_EDGE_DONE);
    end
  end

  assign acquiring_o = (state_q == DAFS_ACQ);
  assign converting_o = (state_q == DAFS_CONV);
  assign power_down_o = (state_q == DAFS_DOWN) || (state_q == DAFS_IDLE)
                        || (state_q == DAFS_ARMED);
  assign conv_abort_o = abort_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  pin_float_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_s_q |=> sdata_oe_n_o && power_down_o)
    else $error("result pin driven while select high");

  frame_open_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_fall |=> in_frame_q && !sdata_oe_n_o)
    else $error("frame did not open on select fall");

  acq_span_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    acquiring_o |-> in_span(cnt_q, `DAFS_EDGE_FIRST, `DAFS_EDGE_ACQ_HI))
    else $error("acquisition outside edges one to three");

  conv_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(converting_o) |-> cnt_q == `DAFS_EDGE_CONV && $past(pop_if.ready))
    else $error("conversion did not start at edge four");

  conv_span_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    converting_o |-> in_span(cnt_q, `DAFS_EDGE_CONV, `DAFS_EDGE_CONV_HI))
    else $error("conversion outside twelve cycles");

  lead_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cs_s_q && in_span(cnt_q, `DAFS_EDGE_FIRST, `DAFS_EDGE_CONV)
    |-> !sdata_o)
    else $error("leading zeros not driven");

  chan_a_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick && !cs_s_q && in_span(cnt_d, `DAFS_EDGE_A_LO, `DAFS_EDGE_A_HI)
    |=> sdata_o == word_q.a[4'(`DAFS_EDGE_A_HI - cnt_q)])
    else $error("channel A bit out of order");

  chan_b_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick && !cs_s_q && in_span(cnt_d, `DAFS_EDGE_B_LO, `DAFS_EDGE_B_HI)
    |=> sdata_o == word_q.b[4'(`DAFS_EDGE_B_HI - cnt_q)])
    else $error("channel B bit out of order");

  frame_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_frame_q && !cs_rise && sclk_fall && cnt_q == `DAFS_EDGE_LAST
    |=> cnt_q == `DAFS_EDGE_FIRST && acquiring_o)
    else $error("frame did not wrap into acquisition");

  high_clk_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_fall && clk_s_q |=> cnt_q == `DAFS_EDGE_NONE && !acquiring_o)
    else $error("acquired before first clock fall");

  low_clk_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_fall && !clk_s_q |=> cnt_q == `DAFS_EDGE_FIRST && acquiring_o)
    else $error("select fall not counted as edge one");

  abort_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_rise && in_frame_q && cnt_q < `DAFS_EDGE_DONE
    |=> conv_abort_o ##1 !conv_abort_o)
    else $error("early select rise not aborted");

  done_down_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !cs_s_q && in_span(cnt_q, `DAFS_EDGE_DONE, `DAFS_EDGE_LAST)
    && !$changed(cnt_q) |-> power_down_o)
    else $error("not powered down after conversion");

endmodule

// ===== hw/dafs_map.svh
`ifndef DAFS_MAP_SVH
`define DAFS_MAP_SVH

// ---------------------------------------------------------------
// Result format
// ---------------------------------------------------------------
`define DAFS_RES_W 12
`define DAFS_WORD_W 24
`define DAFS_CODE_POS_FS 12'h7FF
`define DAFS_CODE_NEG_FS 12'h800
`define DAFS_FIFO_DEPTH 8

// ---------------------------------------------------------------
// Frame edge numbers
// ---------------------------------------------------------------
`define DAFS_CNT_W 6
`define DAFS_EDGE_NONE 6'h00
`define DAFS_EDGE_FIRST 6'h01
`define DAFS_EDGE_ACQ_HI 6'h03
`define DAFS_EDGE_CONV 6'h04
`define DAFS_EDGE_CONV_HI 6'h0F
`define DAFS_EDGE_DONE 6'h10
`define DAFS_EDGE_A_LO 6'h05
`define DAFS_EDGE_A_HI 6'h10
`define DAFS_EDGE_B_LO 6'h15
`define DAFS_EDGE_B_HI 6'h20
`define DAFS_EDGE_LAST 6'h20

`endif

// ===== hw/dafs_pkg.sv
`include "dafs_map.svh"

package dafs_pkg;

  typedef logic [`DAFS_RES_W-1:0] dafs_code_t;
  typedef logic [`DAFS_CNT_W-1:0] dafs_cnt_t;

  typedef struct packed {
    dafs_code_t a;
    dafs_code_t b;
  } dafs_word_t;

  typedef enum logic [2:0] {
    DAFS_DOWN,
    DAFS_ARMED,
    DAFS_ACQ,
    DAFS_CONV,
    DAFS_IDLE
  } dafs_state_t;

endpackage

// ===== hw/dafs_stream_if.sv
`timescale 1ns/1ps

interface dafs_stream_if #(
  parameter int W = 24
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== hw/dafs_fifo.sv
`timescale 1ns/1ps
`include "dafs_map.svh"

module dafs_fifo
  import dafs_pkg::*;
#(
  parameter int WIDTH = `DAFS_WORD_W,
  parameter int DEPTH = `DAFS_FIFO_DEPTH
) (
  input wire logic clk_i,   // System clock
  input wire logic rst_n_i, // Sync reset, active low
  dafs_stream_if.snk push_s, // Filling side
  dafs_stream_if.src pop_s   // Draining side
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push_fire;
  logic pop_fire;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign push_s.ready = (cnt_q != (AW + 1)'(DEPTH));
  assign pop_s.valid = (cnt_q != '0);
  assign pop_s.data = mem_q[rd_q];
  assign push_fire = push_s.valid & push_s.ready;
  assign pop_fire = pop_s.valid & pop_s.ready;

  always_ff @(posedge clk_i) begin
    if (push_fire) begin
      mem_q[wr_q] <= push_s.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push_fire) begin
        wr_q <= next_ptr(wr_q);
      end
      if (pop_fire) begin
        rd_q <= next_ptr(rd_q);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (push_fire && !pop_fire) begin
      cnt_q <= cnt_q + (AW + 1)'(1);
    end else if (pop_fire && !push_fire) begin
      cnt_q <= cnt_q - (AW + 1)'(1);
    end
  end

  fifo_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    push_fire && !pop_fire |=> cnt_q == $past(cnt_q) + (AW + 1)'(1))
    else $error("fifo level did not rise on push");

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_q <= (AW + 1)'(DEPTH))
    else $error("fifo level beyond depth");

endmodule

// ===== verification/dafs_host_model.sv
`timescale 1ns/1ps

module dafs_host_model (
  input wire logic clk_i,   // System clock
  input wire logic sdata_i, // Serial result bit
  input wire logic oe_n_i,  // Result pin enable, active low
  input wire logic acq_i,   // Acquisition phase
  input wire logic conv_i,  // Conversion phase
  input wire logic pd_i,    // Power-down phase
  input wire logic abort_i, // Abort pulse
  output logic cs_n_o,      // Chip select, active low
  output logic sclk_o       // Serial clock, 8 system cycles
);
  logic [63:0] got;
  logic [63:0] acq_v;
  logic [63:0] conv_v;
  logic [63:0] pd_v;
  logic oe_bad;
  logic abort_seen;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end

  // ---------------------------------------------------------------
  // Frame: mode 0 clock low, 1 clock high, 2 both fall together
  // ---------------------------------------------------------------
  task automatic frame(input int n, input int mode);
    got = '0;
    acq_v = '0;
    conv_v = '0;
    pd_v = '0;
    oe_bad = 1'b0;
    if (mode != 0) begin
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    cs_n_o <= 1'b0;
    if (mode == 2) begin
      sclk_o <= 1'b0;
    end
    if (mode == 1) begin
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      got = {got[62:0], sdata_i};
      acq_v = {acq_v[62:0], acq_i};
      conv_v = {conv_v[62:0], conv_i};
      pd_v = {pd_v[62:0], pd_i};
      oe_bad = oe_bad | oe_n_i;
      repeat (4) @(posedge clk_i);
      if (i < n - 1) begin
        sclk_o <= 1'b0;
      end
    end
    cs_n_o <= 1'b1;
    abort_seen = 1'b0;
    repeat (8) begin
      @(posedge clk_i);
      abort_seen = abort_seen | abort_i;
    end
    // Clock parks low between frames
    sclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ===== verification/dafs_seq_tb.sv
`timescale 1ns/1ps

module dafs_seq_tb;
  logic clk_i, rst_n_i, cs_n, sclk, valid, ready, sdata, oe_n;
  logic acq, conv, pd, abrt;
  logic [11:0] a_in, b_in;
  logic [11:0] va [9];
  logic [11:0] vb [9];
  int fail_count, tests_run;
  localparam logic [31:0] ACQ_P = 32'hE000_0000;
  localparam logic [31:0] CONV_P = 32'h1FFE_0000;
  localparam logic [31:0] PD_P = 32'h0001_FFFF;

  dafs_seq i_dafs_seq (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .sample_valid_i(valid), .sample_ready_o(ready),
    .channel_a_difference_input_i(a_in),
    .channel_b_difference_input_i(b_in),
    .sdata_o(sdata), .sdata_oe_n_o(oe_n), .acquiring_o(acq),
    .converting_o(conv), .power_down_o(pd), .conv_abort_o(abrt)
  );

  dafs_host_model i_dafs_host_model (
    .clk_i(clk_i), .sdata_i(sdata), .oe_n_i(oe_n), .acq_i(acq),
    .conv_i(conv), .pd_i(pd), .abort_i(abrt), .cs_n_o(cs_n),
    .sclk_o(sclk)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] fr(input int k);
    return {4'h0, va[k], 4'h0, vb[k]};
  endfunction

  function automatic logic [63:0] rep(input logic [31:0] p, input int n);
    return (n == 64) ? {p, p} : {32'h0000_0000, p};
  endfunction

  task push(input int k);
    int n;
    a_in <= va[k];
    b_in <= vb[k];
    valid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task frame_ok(input int n, input int mode, input logic [63:0] eg);
    i_dafs_host_model.frame(n, mode);
    check(i_dafs_host_model.got, eg);
    check(i_dafs_host_model.acq_v, rep(ACQ_P, n));
    check(i_dafs_host_model.conv_v, rep(CONV_P, n));
    check(i_dafs_host_model.pd_v, rep(PD_P, n));
    check(i_dafs_host_model.oe_bad, 1'b0);
    check(i_dafs_host_model.abort_seen, 1'b0);
    check({oe_n, pd, sdata}, 3'b110);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    check({oe_n, pd, acq, conv, abrt, sdata, ready}, 7'h61);
  endtask

  task t_fill;
    for (int k = 0; k < 8; k++) push(k);
    a_in <= va[8];
    b_in <= vb[8];
    repeat (4) @(posedge clk_i);
    check(ready, 1'b0);
    valid <= 1'b0;
    @(posedge clk_i);
  endtask

  task t_modes;
    for (int m = 0; m < 3; m++) begin
      frame_ok(32, m, {32'h0000_0000, fr(m)});
    end
  endtask

  task t_continuous;
    frame_ok(64, 0, {fr(3), fr(4)});
  endtask

  task t_abort;
    i_dafs_host_model.frame(8, 1);
    check(i_dafs_host_model.got, {56'h0, 4'h0, va[5][11:8]});
    check(i_dafs_host_model.abort_seen, 1'b1);
    check({oe_n, pd, sdata}, 3'b110);
  endtask

  task t_drain;
    frame_ok(32, 2, {32'h0000_0000, fr(6)});
    frame_ok(32, 0, {32'h0000_0000, fr(7)});
    frame_ok(32, 1, {32'h0000_0000, fr(7)});
    check(ready, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    valid = 1'b0;
    a_in = 12'h000;
    b_in = 12'h000;
    fail_count = 0;
    tests_run = 0;
    va = '{12'h7FF, 12'h800, 12'hFFF, 12'h001, 12'h000, 12'hA5C,
           12'h5A3, 12'h123, 12'hABC};
    vb = '{12'h800, 12'h7FF, 12'h001, 12'hFFF, 12'h3C3, 12'h000,
           12'hC3C, 12'hFED, 12'hDEF};
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_fill();
    t_modes();
    t_continuous();
    t_abort();
    t_drain();
    report_and_stop();
  end
endmodule
